// >>> logic/sdsup_cfg.svh
// constants for the sequence directional supervisor
`ifndef SDSUP_CFG_SVH
`define SDSUP_CFG_SVH
`define SDSUP_CLK_HZ 25000000
`define SDSUP_COORD_STEP_US 1000
`define SDSUP_ANG_MAX 7'h5A
`define SDSUP_ANG_DEF 7'h2D
`define SDSUP_BLOCK_DEF 1'h0
`define SDSUP_VMIN_LO 10'h005
`define SDSUP_VMIN_HI 10'h3E8
`define SDSUP_VMIN_DEF 10'h014
`define SDSUP_K_MAX 13'h1388
`define SDSUP_K_DEF 13'h0000
`define SDSUP_K_SCALE 100
`define SDSUP_COORD_MAX 5'h1E
`define SDSUP_COORD_DEF 5'h00
`define SDSUP_RATED_I 1000
`define SDSUP_IMIN_PCT 2
`define SDSUP_ROT_FRAC 14
`define SDSUP_SAMPLES_PER_CYCLE 16
`define SDSUP_MEM_CYCLES 2
`define SDSUP_MEM_AW 5
`endif

// >>> logic/sdsup_pkg.sv
// types shared by the sequence directional supervisor
package sdsup_pkg;
    typedef enum logic {
        sdsup_dir_fwd,
        sdsup_dir_rev
    } sdsup_dir_mode_t;
endpackage

// >>> logic/sdsup_top.sv
// sequence directional supervisor: element, timer and top
`timescale 1ns/1ps
`include "sdsup_cfg.svh"

module sdsup_coord_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    input wire logic [19:0] limit,
    output logic timed
);
    logic [19:0] cnt_reg;

    // saturates so a long fault never wraps back below the limit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 20'h00000;
        end else if (!level) begin
            cnt_reg <= 20'h00000;
        end else if (cnt_reg != 20'hFFFFF) begin
            cnt_reg <= cnt_reg + 20'h00001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timed <= 1'b0;
        end else begin
            timed <= level && (cnt_reg >= limit);
        end
    end
endmodule

module sdsup_dir_elem #(
    parameter bit NEG_V = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic stb,
    input wire logic signed [15:0] op_re,
    input wire logic signed [15:0] op_im,
    input wire logic signed [15:0] v_re,
    input wire logic signed [15:0] v_im,
    input wire logic [12:0] comp,
    input wire logic [6:0] ang,
    input wire logic [9:0] vmin,
    input wire logic inhibit,
    input wire logic invert,
    input wire logic block_lp,
    input wire sdsup_pkg::sdsup_dir_mode_t mode,
    output logic en,
    output logic lp,
    output logic fwd,
    output logic rev
);
    import sdsup_pkg::*;

    localparam logic [32:0] IMIN = 33'(`SDSUP_RATED_I * `SDSUP_IMIN_PCT / 100);
    localparam logic [32:0] IMIN_SQ = 33'(IMIN * IMIN);

    function automatic logic signed [16:0] cos_tab(input logic [3:0] i);
        logic signed [16:0] r;
        r = 17'sh00000;
        case (i)
            4'h0: r = 17'sh04000;
            4'h1: r = 17'sh03F07;
            4'h2: r = 17'sh03C24;
            4'h3: r = 17'sh0376D;
            4'h4: r = 17'sh03107;
            4'h5: r = 17'sh02923;
            4'h6: r = 17'sh02000;
            4'h7: r = 17'sh015E4;
            4'h8: r = 17'sh00B1D;
            default: r = 17'sh00000;
        endcase
        return r;
    endfunction

    // 10 degree table, linear in between: under 0.2 degree of error
    function automatic logic signed [15:0] cos_q(input logic [6:0] a);
        logic [3:0] i;
        logic [3:0] f;
        logic signed [16:0] lo;
        logic signed [21:0] p;
        i = 4'(a / 7'h0A);
        f = 4'(a % 7'h0A);
        lo = cos_tab(i);
        p = (cos_tab(i + 4'h1) - lo) * $signed({1'b0, f});
        return 16'(lo + 17'(p / 22'sh0000A));
    endfunction

    logic signed [15:0] cos_w;
    logic signed [15:0] sin_w;
    logic signed [32:0] rr_w;
    logic signed [32:0] ri_w;
    logic [32:0] isq_w;
    logic signed [30:0] kr_w;
    logic signed [30:0] ki_w;
    logic signed [24:0] fr_w;
    logic signed [24:0] fi_w;
    logic [50:0] vsq_w;
    logic signed [41:0] pr_w;
    logic signed [41:0] pi_w;
    logic signed [57:0] t_w;

    logic [2:0] vld_reg;
    logic signed [15:0] ir_reg;
    logic signed [15:0] ii_reg;
    logic signed [15:0] vr_reg;
    logic signed [15:0] vi_reg;
    logic signed [16:0] rr_reg;
    logic signed [16:0] ri_reg;
    logic i_ok_reg;
    logic signed [24:0] fr_reg;
    logic signed [24:0] fi_reg;
    logic v_ok_reg;
    logic signed [41:0] pr_reg;
    logic signed [41:0] pi_reg;
    logic crit_w;
    logic dir_w;

    always_comb begin
        cos_w = cos_q(ang);
        sin_w = cos_q(`SDSUP_ANG_MAX - ang);
        rr_w = ir_in_rot(op_re, op_im, cos_w, sin_w);
        ri_w = op_re * sin_w + op_im * cos_w;
        isq_w = op_re * op_re + op_im * op_im;
    end

    function automatic logic signed [32:0] ir_in_rot(
        input logic signed [15:0] re,
        input logic signed [15:0] im,
        input logic signed [15:0] c,
        input logic signed [15:0] s
    );
        logic signed [32:0] r;
        r = re * c - im * s;
        return r;
    endfunction

    // current rotated by the characteristic angle, scaled by the factor
    always_comb begin
        kr_w = rr_reg * $signed({1'b0, comp});
        ki_w = ri_reg * $signed({1'b0, comp});
        fr_w = 25'(kr_w / 31'(`SDSUP_K_SCALE))
            + (NEG_V ? -25'(vr_reg) : 25'(vr_reg));
        fi_w = 25'(ki_w / 31'(`SDSUP_K_SCALE))
            + (NEG_V ? -25'(vi_reg) : 25'(vi_reg));
    end

    // zone test: Re(Iop * conj(Fpol) * e^(j*ang)) >= 0 is the window
    always_comb begin
        vsq_w = fr_reg * fr_reg + fi_reg * fi_reg;
        pr_w = ir_reg * fr_reg + ii_reg * fi_reg;
        pi_w = ii_reg * fr_reg - ir_reg * fi_reg;
        t_w = pr_reg * cos_w - pi_reg * sin_w;
        crit_w = (t_w >= 58'sh0);
        dir_w = crit_w ^ invert;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vld_reg <= 3'h0;
        end else begin
            vld_reg <= {vld_reg[1:0], stb};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ir_reg <= 16'sh0000;
            ii_reg <= 16'sh0000;
            vr_reg <= 16'sh0000;
            vi_reg <= 16'sh0000;
            rr_reg <= 17'sh00000;
            ri_reg <= 17'sh00000;
            i_ok_reg <= 1'b0;
        end else if (stb) begin
            ir_reg <= op_re;
            ii_reg <= op_im;
            vr_reg <= v_re;
            vi_reg <= v_im;
            rr_reg <= rr_w[`SDSUP_ROT_FRAC+16:`SDSUP_ROT_FRAC];
            ri_reg <= ri_w[`SDSUP_ROT_FRAC+16:`SDSUP_ROT_FRAC];
            i_ok_reg <= isq_w > IMIN_SQ;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fr_reg <= 25'sh0000000;
            fi_reg <= 25'sh0000000;
        end else if (vld_reg[0]) begin
            fr_reg <= fr_w;
            fi_reg <= fi_w;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            v_ok_reg <= 1'b0;
            pr_reg <= 42'sh0;
            pi_reg <= 42'sh0;
        end else if (vld_reg[1]) begin
            v_ok_reg <= vsq_w > 51'(vmin * vmin);
            pr_reg <= pr_w;
            pi_reg <= pi_w;
        end
    end

    // blocked until the first evaluation after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en <= 1'b0;
            lp <= 1'b0;
            fwd <= 1'b0;
            rev <= 1'b0;
        end else if (vld_reg[2]) begin
            if (inhibit) begin
                en <= 1'b1;
                lp <= 1'b0;
                fwd <= 1'b0;
                rev <= 1'b0;
            end else if (!(i_ok_reg && v_ok_reg)) begin
                en <= !block_lp;
                lp <= 1'b1;
                fwd <= 1'b0;
                rev <= 1'b0;
            end else begin
                en <= (mode == sdsup_dir_fwd) ? dir_w : !dir_w;
                lp <= 1'b0;
                fwd <= dir_w;
                rev <= !dir_w;
            end
        end
    end
endmodule

module sdsup_top #(
    parameter int CYC_PER_STEP = `SDSUP_CLK_HZ / 1000000 * `SDSUP_COORD_STEP_US
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sample_strobe,
    input wire logic signed [15:0] negseq_i_re,
    input wire logic signed [15:0] negseq_i_im,
    input wire logic signed [15:0] negseq_v_re,
    input wire logic signed [15:0] negseq_v_im,
    input wire logic signed [15:0] posseq_i_re,
    input wire logic signed [15:0] posseq_i_im,
    input wire logic signed [15:0] posseq_v_re,
    input wire logic signed [15:0] posseq_v_im,
    input wire logic fault_detect,
    input wire logic seq_direction_inhibit,
    input wire logic posseq_direction_inhibit,
    input wire logic direction_invert_in,
    input wire logic trip_direction_invert,
    input wire logic [6:0] negseq_char_angle,
    input wire logic [6:0] posseq_char_angle,
    input wire logic [9:0] negseq_min_volt,
    input wire logic [9:0] posseq_min_volt,
    input wire logic [12:0] negseq_comp_factor,
    input wire logic lack_pol_block,
    input wire logic [4:0] coord_time_ms,
    input wire sdsup_pkg::sdsup_dir_mode_t negseq_dir_mode,
    input wire sdsup_pkg::sdsup_dir_mode_t posseq_dir_mode,
    input wire logic [2:0] posseq_torque_supervision,
    output logic negseq_oc_enable,
    output logic posseq_oc_enable,
    output logic [2:0] phase_oc_enable,
    output logic negseq_no_polarization,
    output logic posseq_no_polarization,
    output logic negseq_inst_forward,
    output logic negseq_inst_reverse,
    output logic posseq_inst_forward,
    output logic posseq_inst_reverse,
    output logic negseq_timed_forward,
    output logic negseq_timed_reverse,
    output logic posseq_timed_forward,
    output logic posseq_timed_reverse
);
    import sdsup_pkg::*;

    localparam int MEM_DEPTH = `SDSUP_SAMPLES_PER_CYCLE * `SDSUP_MEM_CYCLES;

    logic [6:0] nq_ang_reg;
    logic [6:0] pq_ang_reg;
    logic [9:0] nq_vmin_reg;
    logic [9:0] pq_vmin_reg;
    logic [12:0] k_reg;
    logic block_reg;
    logic [4:0] coord_reg;
    logic [19:0] limit_reg;
    logic invert_w;
    logic signed [15:0] mem_re [MEM_DEPTH];
    logic signed [15:0] mem_im [MEM_DEPTH];
    logic [`SDSUP_MEM_AW-1:0] wptr_reg;
    logic signed [15:0] pol_re_reg;
    logic signed [15:0] pol_im_reg;
    logic pol_stb_reg;

    assign invert_w = direction_invert_in | trip_direction_invert;

    // out-of-range settings clamp to the nearest limit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nq_ang_reg <= `SDSUP_ANG_DEF;
            pq_ang_reg <= `SDSUP_ANG_DEF;
        end else begin
            nq_ang_reg <= (negseq_char_angle > `SDSUP_ANG_MAX) ?
                `SDSUP_ANG_MAX : negseq_char_angle;
            pq_ang_reg <= (posseq_char_angle > `SDSUP_ANG_MAX) ?
                `SDSUP_ANG_MAX : posseq_char_angle;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nq_vmin_reg <= `SDSUP_VMIN_DEF;
            pq_vmin_reg <= `SDSUP_VMIN_DEF;
        end else begin
            nq_vmin_reg <= (negseq_min_volt < `SDSUP_VMIN_LO) ? `SDSUP_VMIN_LO :
                (negseq_min_volt > `SDSUP_VMIN_HI) ? `SDSUP_VMIN_HI : negseq_min_volt;
            pq_vmin_reg <= (posseq_min_volt < `SDSUP_VMIN_LO) ? `SDSUP_VMIN_LO :
                (posseq_min_volt > `SDSUP_VMIN_HI) ? `SDSUP_VMIN_HI : posseq_min_volt;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            k_reg <= `SDSUP_K_DEF;
            block_reg <= `SDSUP_BLOCK_DEF;
            coord_reg <= `SDSUP_COORD_DEF;
            limit_reg <= 20'h00000;
        end else begin
            k_reg <= (negseq_comp_factor > `SDSUP_K_MAX) ?
                `SDSUP_K_MAX : negseq_comp_factor;
            block_reg <= lack_pol_block;
            coord_reg <= (coord_time_ms > `SDSUP_COORD_MAX) ?
                `SDSUP_COORD_MAX : coord_time_ms;
            limit_reg <= 20'(coord_reg * CYC_PER_STEP);
        end
    end

    // ring of two cycles of V1; the slot about to be overwritten is oldest
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wptr_reg <= '0;
        end else if (sample_strobe) begin
            wptr_reg <= wptr_reg + 5'h01;
        end
    end

    // cleared so the reference reads as zero until two cycles are stored
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int s = 0; s < MEM_DEPTH; s++) begin
                mem_re[s] <= 16'sh0000;
                mem_im[s] <= 16'sh0000;
            end
        end else if (sample_strobe) begin
            mem_re[wptr_reg] <= posseq_v_re;
            mem_im[wptr_reg] <= posseq_v_im;
        end
    end

    // frozen while the fault detector is up, so the reference predates it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pol_re_reg <= 16'sh0000;
            pol_im_reg <= 16'sh0000;
            pol_stb_reg <= 1'b0;
        end else begin
            pol_stb_reg <= sample_strobe;
            if (sample_strobe && !fault_detect) begin
                pol_re_reg <= mem_re[wptr_reg];
                pol_im_reg <= mem_im[wptr_reg];
            end
        end
    end

    logic signed [15:0] pq_ir_reg;
    logic signed [15:0] pq_ii_reg;

    // align currents with the memorized voltage one cycle later
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pq_ir_reg <= 16'sh0000;
            pq_ii_reg <= 16'sh0000;
        end else if (sample_strobe) begin
            pq_ir_reg <= posseq_i_re;
            pq_ii_reg <= posseq_i_im;
        end
    end

    sdsup_dir_elem #(.NEG_V(1'b1)) u_negseq (
        .clk(sys_clk),
        .rst(rst),
        .stb(sample_strobe),
        .op_re(negseq_i_re),
        .op_im(negseq_i_im),
        .v_re(negseq_v_re),
        .v_im(negseq_v_im),
        .comp(k_reg),
        .ang(nq_ang_reg),
        .vmin(nq_vmin_reg),
        .inhibit(seq_direction_inhibit),
        .invert(invert_w),
        .block_lp(block_reg),
        .mode(negseq_dir_mode),
        .en(negseq_oc_enable),
        .lp(negseq_no_polarization),
        .fwd(negseq_inst_forward),
        .rev(negseq_inst_reverse)
    );

    sdsup_dir_elem #(.NEG_V(1'b0)) u_posseq (
        .clk(sys_clk),
        .rst(rst),
        .stb(pol_stb_reg),
        .op_re(pq_ir_reg),
        .op_im(pq_ii_reg),
        .v_re(pol_re_reg),
        .v_im(pol_im_reg),
        .comp(13'h0000),
        .ang(pq_ang_reg),
        .vmin(pq_vmin_reg),
        .inhibit(posseq_direction_inhibit),
        .invert(invert_w),
        .block_lp(block_reg),
        .mode(posseq_dir_mode),
        .en(posseq_oc_enable),
        .lp(posseq_no_polarization),
        .fwd(posseq_inst_forward),
        .rev(posseq_inst_reverse)
    );

    // unselected phases run unsupervised
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_oc_enable <= 3'h7;
        end else begin
            for (int p = 0; p < 3; p++) begin
                phase_oc_enable[p] <= !posseq_torque_supervision[p]
                    || posseq_oc_enable;
            end
        end
    end

    sdsup_coord_timer u_nq_tf (
        .clk(sys_clk),
        .rst(rst),
        .level(negseq_inst_forward),
        .limit(limit_reg),
        .timed(negseq_timed_forward)
    );

    sdsup_coord_timer u_nq_tr (
        .clk(sys_clk),
        .rst(rst),
        .level(negseq_inst_reverse),
        .limit(limit_reg),
        .timed(negseq_timed_reverse)
    );

    sdsup_coord_timer u_pq_tf (
        .clk(sys_clk),
        .rst(rst),
        .level(posseq_inst_forward),
        .limit(limit_reg),
        .timed(posseq_timed_forward)
    );

    sdsup_coord_timer u_pq_tr (
        .clk(sys_clk),
        .rst(rst),
        .level(posseq_inst_reverse),
        .limit(limit_reg),
        .timed(posseq_timed_reverse)
    );
endmodule

// >>> bench/sdsup_phasor_src.sv
// strobe source standing in for the phasor measurement logic
`timescale 1ns/1ps
module sdsup_phasor_src #(
    parameter int GAP = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] want,
    output logic strobe,
    output logic [7:0] n_sent
);
    logic [3:0] gap_reg;
    // strobes stay GAP apart, wider than the six-cycle pipeline needs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe <= 1'b0;
            n_sent <= 8'h00;
            gap_reg <= 4'h0;
        end else if (gap_reg != 4'h0) begin
            strobe <= 1'b0;
            gap_reg <= gap_reg - 4'h1;
        end else if (n_sent != want) begin
            strobe <= 1'b1;
            n_sent <= n_sent + 8'h01;
            gap_reg <= 4'(GAP - 1);
        end else begin
            strobe <= 1'b0;
        end
    end
endmodule

// >>> bench/sdsup_top_asserts.sv
// concurrent checks on the supervisor's ports
`timescale 1ns/1ps
module sdsup_top_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sample_strobe,
    input wire logic seq_direction_inhibit,
    input wire logic posseq_direction_inhibit,
    input wire logic lack_pol_block,
    input wire sdsup_pkg::sdsup_dir_mode_t negseq_dir_mode,
    input wire logic [2:0] posseq_torque_supervision,
    input wire logic negseq_oc_enable,
    input wire logic posseq_oc_enable,
    input wire logic [2:0] phase_oc_enable,
    input wire logic negseq_no_polarization,
    input wire logic posseq_no_polarization,
    input wire logic negseq_inst_forward,
    input wire logic negseq_inst_reverse,
    input wire logic posseq_inst_forward,
    input wire logic negseq_timed_forward
);
    import sdsup_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_neg_inhibit: assert property (sample_strobe ##1 seq_direction_inhibit [*4]
        |=> negseq_oc_enable && !negseq_no_polarization
        && !negseq_inst_forward && !negseq_inst_reverse)
        else $error("negseq not neutral under inhibit");
    chk_neg_rev_mode: assert property (sample_strobe
        ##1 (!seq_direction_inhibit && negseq_dir_mode == sdsup_dir_rev) [*4]
        |=> negseq_no_polarization || negseq_oc_enable == negseq_inst_reverse)
        else $error("reverse mode enable wrong");
    chk_lack_block: assert property (sample_strobe
        ##1 (!seq_direction_inhibit && lack_pol_block) [*4]
        |=> !negseq_no_polarization
        || !(negseq_oc_enable || negseq_inst_forward || negseq_inst_reverse))
        else $error("negseq not blocked on lack");
    chk_lack_open: assert property (sample_strobe
        ##1 (!seq_direction_inhibit && !lack_pol_block) [*4]
        |=> !negseq_no_polarization || negseq_oc_enable)
        else $error("negseq not enabled on lack");
    chk_pos_inhibit: assert property (sample_strobe ##1 posseq_direction_inhibit [*5]
        |=> posseq_oc_enable && !posseq_no_polarization)
        else $error("posseq not neutral under inhibit");
    chk_phase_torque: assert property (!$past(rst) && !$past(rst, 2)
        && posseq_torque_supervision == $past(posseq_torque_supervision)
        && posseq_torque_supervision == $past(posseq_torque_supervision, 2)
        |-> phase_oc_enable == (~posseq_torque_supervision | {3{$past(posseq_oc_enable)}}))
        else $error("phase enable does not follow selection");
    chk_neg_change: assert property ($changed(negseq_oc_enable)
        |-> $past(sample_strobe, 4))
        else $error("negseq enable moved without strobe");
    chk_pos_change: assert property ($changed(posseq_inst_forward)
        |-> $past(sample_strobe, 5))
        else $error("posseq direction moved without strobe");
    chk_timed_fwd: assert property (negseq_timed_forward
        |-> $past(negseq_inst_forward))
        else $error("timed forward without instantaneous");
endmodule

bind sdsup_top sdsup_top_asserts u_chk (.sys_clk, .rst, .sample_strobe,
    .seq_direction_inhibit, .posseq_direction_inhibit, .lack_pol_block,
    .negseq_dir_mode, .posseq_torque_supervision, .negseq_oc_enable, .posseq_oc_enable,
    .phase_oc_enable, .negseq_no_polarization, .posseq_no_polarization,
    .negseq_inst_forward, .negseq_inst_reverse, .posseq_inst_forward,
    .negseq_timed_forward);

// >>> bench/tb.sv
// self-checking bench for the sequence directional supervisor
`timescale 1ns/1ps
module tb;
    import sdsup_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic stb;
    logic [7:0] sent;
    logic [7:0] want = 8'h00;
    logic signed [15:0] i2r = '0, i2i = '0, v2r = '0, v2i = '0;
    logic signed [15:0] i1r = '0, i1i = '0, v1r = '0, v1i = '0;
    logic fdet = 1'b0, inh2 = 1'b0, inh1 = 1'b0, inva = 1'b0, invb = 1'b0, blk = 1'b0;
    logic [6:0] ang2 = 7'h00, ang1 = 7'h00;
    logic [9:0] vmin2 = 10'h014, vmin1 = 10'h014;
    logic [12:0] kf = 13'h0000;
    logic [4:0] coord = 5'h00;
    logic [2:0] sup = 3'h0;
    sdsup_dir_mode_t m2 = sdsup_dir_fwd;
    sdsup_dir_mode_t m1 = sdsup_dir_fwd;
    logic en2, en1, lp2, lp1, f2, r2, f1, r1, tf2, tr2, tf1, tr1;
    logic [2:0] ph;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    sdsup_phasor_src src (.clk(clk), .rst(rst), .want(want), .strobe(stb), .n_sent(sent));
    sdsup_top #(.CYC_PER_STEP(4)) dut (.sys_clk(clk), .rst(rst), .sample_strobe(stb),
        .negseq_i_re(i2r), .negseq_i_im(i2i), .negseq_v_re(v2r), .negseq_v_im(v2i),
        .posseq_i_re(i1r), .posseq_i_im(i1i), .posseq_v_re(v1r), .posseq_v_im(v1i),
        .fault_detect(fdet), .seq_direction_inhibit(inh2), .posseq_direction_inhibit(inh1),
        .direction_invert_in(inva), .trip_direction_invert(invb),
        .negseq_char_angle(ang2), .posseq_char_angle(ang1), .negseq_min_volt(vmin2),
        .posseq_min_volt(vmin1), .negseq_comp_factor(kf), .lack_pol_block(blk),
        .coord_time_ms(coord), .negseq_dir_mode(m2), .posseq_dir_mode(m1),
        .posseq_torque_supervision(sup), .negseq_oc_enable(en2), .posseq_oc_enable(en1),
        .phase_oc_enable(ph), .negseq_no_polarization(lp2), .posseq_no_polarization(lp1),
        .negseq_inst_forward(f2), .negseq_inst_reverse(r2), .posseq_inst_forward(f1),
        .posseq_inst_reverse(r1), .negseq_timed_forward(tf2), .negseq_timed_reverse(tr2),
        .posseq_timed_forward(tf1), .posseq_timed_reverse(tr1));

    task automatic complete_run();
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, about twenty times the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [7:0] nv();
        return {4'h0, en2, lp2, f2, r2};
    endfunction

    function automatic logic [7:0] pv();
        return {4'h0, en1, lp1, f1, r1};
    endfunction

    // k strobes, then wait past the phase enable stage
    task automatic go(input int k);
        want = sent + 8'(k);
        while (sent != want) @(posedge clk);
        repeat (9) @(posedge clk);
        #1;
    endtask

    task automatic t_dir();
        logic d;
        i2r = 16'sh0064;
        for (int k = 0; k < 16; k++) begin
            m2 = sdsup_dir_mode_t'(k[0]);
            v2r = k[1] ? 16'sh0064 : -16'sh0064;
            {inva, invb} = 2'(k >> 2);
            d = !k[1] ^ (k[3] | k[2]);
            go(1);
            chk("neg dir", nv(), {4'h0, k[0] ? !d : d, 1'b0, d, !d});
        end
        {inva, invb} = 2'h0;
        m2 = sdsup_dir_fwd;
    endtask

    task automatic t_zone();
        int t[5][4] = '{'{0, -100, 0, 1}, '{0, 100, 0, 1}, '{1, -100, 0, 0},
            '{0, 100, 90, 0}, '{-97, -26, 120, 1}};
        for (int k = 0; k < 5; k++) begin
            v2r = 16'(t[k][0]);
            v2i = 16'(t[k][1]);
            ang2 = 7'(t[k][2]);
            go(1);
            chk("neg zone", nv(), {4'h0, t[k][3] != 0, 1'b0, t[k][3] != 0, t[k][3] == 0});
        end
        v2i = '0;
        ang2 = 7'h00;
    endtask

    task automatic t_comp();
        v2r = 16'sh0064;
        for (int k = 0; k < 2; k++) begin
            kf = k ? 13'h012C : 13'h0000;
            go(1);
            chk("neg comp", nv(), k ? 8'h0A : 8'h01);
        end
        kf = 13'h0000;
    endtask

    task automatic t_lack();
        int t[6][5] = '{'{20, -100, 0, 20, 12}, '{21, -100, 0, 20, 10},
            '{100, -20, 0, 20, 12}, '{100, -21, 0, 20, 10}, '{20, -100, 1, 20, 4},
            '{100, -5, 1, 0, 4}};
        for (int k = 0; k < 6; k++) begin
            i2r = 16'(t[k][0]);
            v2r = 16'(t[k][1]);
            blk = 1'(t[k][2]);
            vmin2 = 10'(t[k][3]);
            go(1);
            chk("neg lack", nv(), 8'(t[k][4]));
        end
        blk = 1'b0;
        vmin2 = 10'h014;
    endtask

    task automatic t_inhib();
        inh2 = 1'b1;
        i2r = 16'sh0064;
        v2r = 16'sh0064;
        go(1);
        chk("neg inhibit", nv(), 8'h08);
        i2r = 16'sh0005;
        blk = 1'b1;
        go(1);
        chk("neg inhibit lack", nv(), 8'h08);
        inh2 = 1'b0;
        blk = 1'b0;
    endtask

    // delay from first instantaneous forward to its timed copy
    task automatic t_timed(input logic [4:0] c);
        int n;
        coord = c;
        i2r = 16'sh0064;
        v2r = 16'sh0064;
        go(1);
        chk("timed rev on", {7'h00, tr2}, 8'(c == 0));
        v2r = -16'sh0064;
        want = sent + 8'h01;
        n = 0;
        while (f2 !== 1'b1) @(posedge clk);
        while (tf2 !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("timed fwd delay", 8'(n), 8'(c * 4 + 1));
        repeat (4) @(posedge clk);
        #1;
        chk("timed rev", {7'h00, tr2}, 8'h00);
    endtask

    task automatic t_pos();
        int t[6][8] = '{'{-100, 0, 0, 0, 0, 5, 1, 2}, '{-100, 1, 0, 0, 0, 5, 9, 7},
            '{-100, 0, 1, 0, 0, 5, 10, 7}, '{100, 0, 0, 1, 1, 6, 8, 7},
            '{20, 0, 0, 0, 1, 6, 4, 1}, '{20, 0, 0, 0, 0, 3, 12, 7}};
        i1r = 16'sh0064;
        v1r = 16'sh0064;
        go(1);
        chk("pos fill", pv(), 8'h0C);
        go(33);
        chk("pos fwd", pv(), 8'h0A);
        fdet = 1'b1;
        v1r = -16'sh0064;
        go(34);
        chk("pos frozen", pv(), 8'h0A);
        chk("pos timed", {6'h00, tf1, tr1}, 8'h02);
        for (int k = 0; k < 6; k++) begin
            i1r = 16'(t[k][0]);
            m1 = sdsup_dir_mode_t'(t[k][1]);
            invb = 1'(t[k][2]);
            inh1 = 1'(t[k][3]);
            blk = 1'(t[k][4]);
            sup = 3'(t[k][5]);
            go(1);
            chk("pos case", pv(), 8'(t[k][6]));
            chk("phase enable", {5'h00, ph}, 8'(t[k][7]));
        end
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1;
        chk("neg reset", nv(), 8'h00);
        chk("pos reset", pv(), 8'h00);
        chk("phase reset", {5'h00, ph}, 8'h07);
        rst = 1'b0;
        t_dir();
        t_zone();
        t_comp();
        t_lack();
        t_inhib();
        t_timed(5'h00);
        t_timed(5'h02);
        t_pos();
        complete_run();
    end
endmodule
